// ---- test/board_model.sv ----
// Board-side model of the gate pins seen by the latch
`timescale 1ns/1ps
module board_model (
	// Clock and gate drive
	input  wire       sys_clk_i,
	input  wire [1:0] upper_gate_drive_i,
	// Monitored gate level
	output reg  [1:0] upper_gate_mon_o
);
	// Gate charge lags the drive by one cycle
	initial upper_gate_mon_o = 2'h0;
	always @(posedge sys_clk_i) begin
		upper_gate_mon_o <= upper_gate_drive_i;
	end
endmodule

// ---- test/latch_sva.sv ----
// Assertion checker for the start-up configuration latch
`timescale 1ns/1ps
module latch_sva (
	// Clock and reset
	input wire       sys_clk_i,
	input wire       rst_b_i,
	// Watched ports
	input wire       enable_i,
	input wire       power_saving_request_n_i,
	input wire [1:0] upper_gate_mon_i,
	input wire       two_phase_o,
	input wire       fixed_vid_mode_o,
	input wire       serial_vid_mode_o,
	input wire       droop_en_o,
	input wire       profile_valid_o,
	input wire [2:0] startup_code_o,
	input wire       code_locked_o,
	input wire       phase1_idle_o,
	input wire       discontinuous_conduction_o,
	input wire [1:0] lower_gate_drive_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	mode_pick_a: assert property (profile_valid_o |-> fixed_vid_mode_o ^ serial_vid_mode_o)
		else $error("mode clash");
	fixed_droop_a: assert property (!(fixed_vid_mode_o && droop_en_o))
		else $error("droop in fixed mode");
	lock_rise_a: assert property ($rose(code_locked_o) |-> $past(enable_i) &&
		!$past(enable_i, 2) && profile_valid_o && startup_code_o[2] == !fixed_vid_mode_o)
		else $error("bad lock");
	profile_hold_a: assert property (code_locked_o && $past(code_locked_o) |->
		$stable({two_phase_o, droop_en_o, startup_code_o})) else $error("profile moved");
	unlock_a: assert property (code_locked_o && !enable_i |=> !code_locked_o)
		else $error("lock kept");
	save_req_a: assert property (discontinuous_conduction_o |->
		$past(power_saving_request_n_i) == 1'b0) else $error("bad save mode");
	idle_two_a: assert property (phase1_idle_o |-> two_phase_o)
		else $error("idle in single");
	dead_time_a: assert property ($rose(lower_gate_drive_o[0]) |->
		$past(upper_gate_mon_i[0], 5) == 1'b0) else $error("short dead time");
endmodule
bind startup_configuration_latch latch_sva chk (.*);

// ---- test/startup_configuration_latch_test.sv ----
// Bench for the start-up configuration latch
`timescale 1ns/1ps
module startup_configuration_latch_test;
	reg        clk = 1'b0;
	reg        rst_b = 1'b0;
	reg        strap = 1'b0;
	reg        en = 1'b0;
	reg        vclk = 1'b0;
	reg        vdat = 1'b0;
	reg        psr_n = 1'b1;
	reg        low_cur = 1'b0;
	reg  [1:0] mode = 2'h2;
	reg  [1:0] ureq = 2'h0;
	reg  [1:0] lreq = 2'h0;
	wire [1:0] mon, ug, lg;
	wire [2:0] code;
	wire       two, fix, ser, drp, pv, lock, idle, dcon;
	integer    miscompares = 0;
	integer    total_checks = 0;
	always #2 clk = ~clk;
	startup_configuration_latch uut (.sys_clk_i(clk), .rst_b_i(rst_b), .plane_count_strap_i(strap),
		.offset_mode_select_i(mode), .enable_i(en), .vid_serial_clk_i(vclk),
		.vid_serial_data_i(vdat), .power_saving_request_n_i(psr_n), .low_current_i(low_cur),
		.upper_req_i(ureq), .lower_req_i(lreq), .upper_gate_mon_i(mon), .two_phase_o(two),
		.fixed_vid_mode_o(fix), .serial_vid_mode_o(ser), .droop_en_o(drp), .profile_valid_o(pv),
		.startup_code_o(code), .code_locked_o(lock), .phase1_idle_o(idle),
		.discontinuous_conduction_o(dcon), .upper_gate_drive_o(ug), .lower_gate_drive_o(lg));
	board_model board (.sys_clk_i(clk), .upper_gate_drive_i(ug), .upper_gate_mon_o(mon));
	task give_verdict;
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task boot(input s, input [1:0] m, input c, input d);
		@(posedge clk) rst_b <= 1'b0;
		en <= 1'b0;
		strap <= s;
		mode <= m;
		{vclk, vdat} <= {c, d};
		@(posedge clk) rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		en <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task svi_single;
		boot(1'b0, 2'h2, 1'b1, 1'b0);
		chk({two, fix, ser, drp}, 8'h02);
		chk({lock, code}, 8'h0E);
	endtask
	task fixed_dual;
		boot(1'b1, 2'h1, 1'b0, 1'b1);
		chk({two, fix, ser, drp}, 8'h0C);
		chk({lock, code}, 8'h09);
	endtask
	task por_wait;
		@(posedge clk) rst_b <= 1'b0;
		en <= 1'b0;
		@(posedge clk) rst_b <= 1'b1;
		@(posedge clk) #1 chk(pv, 8'h00);
		@(posedge clk) #1 chk(pv, 8'h01);
	endtask
	task droop_hold;
		boot(1'b1, 2'h0, 1'b1, 1'b1);
		chk({two, fix, ser, drp}, 8'h0B);
		@(posedge clk) strap <= 1'b0;
		mode <= 2'h1;
		repeat (3) @(posedge clk);
		#1 chk({two, fix, drp, lock, code}, 8'h5F);
		@(posedge clk) en <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(lock, 8'h00);
		repeat (4) @(posedge clk);
		en <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({two, fix, drp, lock, code}, 8'h2B);
	endtask
	task por_enable_high;
		@(posedge clk) rst_b <= 1'b0;
		en <= 1'b1;
		@(posedge clk) rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(lock, 8'h00);
		@(posedge clk) en <= 1'b0;
		repeat (2) @(posedge clk);
		en <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(lock, 8'h01);
	endtask
	task gates_save;
		boot(1'b1, 2'h2, 1'b0, 1'b0);
		@(posedge clk) psr_n <= 1'b0;
		low_cur <= 1'b1;
		ureq <= 2'h3;
		repeat (4) @(posedge clk);
		#1 chk({dcon, idle, ug, lg[0]}, 8'h1A);
		@(posedge clk) ureq <= 2'h0;
		lreq <= 2'h1;
		repeat (3) @(posedge clk);
		#1 chk(lg[0], 8'h00);
		repeat (4) @(posedge clk);
		#1 chk(lg[0], 8'h00);
		@(posedge clk) #1 chk(lg[0], 8'h01);
		@(posedge clk) lreq <= 2'h0;
		repeat (3) @(posedge clk);
		#1 chk(lg[0], 8'h00);
		@(posedge clk) psr_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk({dcon, lg[0]}, 8'h01);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		svi_single;
		fixed_dual;
		por_wait;
		droop_hold;
		por_enable_high;
		gates_save;
		give_verdict;
	end
	initial begin
		#4000;
		miscompares = miscompares + 1;
		give_verdict;
	end
endmodule

// ---- verilog/gate_guard.v ----
// Shoot-through guard for one channel's gate pair
`timescale 1ns/1ps
`include "startup_consts.vh"

module gate_guard (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       rst_b_i,
	// Requested drive
	input  wire       run_i,
	input  wire       upper_req_i,
	input  wire       lower_req_i,
	// Monitored upper gate level
	input  wire       upper_gate_mon_i,
	// Gate outputs
	output reg        upper_gate_drive_o,
	output reg        lower_gate_drive_o
);

	reg [3:0] dead_cnt_q;
	wire      upper_off;

	assign upper_off = ~upper_gate_mon_i & ~upper_gate_drive_o;

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dead_cnt_q         <= 4'h0;
			upper_gate_drive_o <= 1'b0;
			lower_gate_drive_o <= 1'b0;
		end else if (!run_i) begin
			dead_cnt_q         <= 4'h0;
			upper_gate_drive_o <= 1'b0;
			lower_gate_drive_o <= 1'b0;
		end else begin
			upper_gate_drive_o <= upper_req_i & ~lower_gate_drive_o & ~lower_req_i;
			if (!upper_off || !lower_req_i) begin
				dead_cnt_q <= 4'h0;
			end else if (dead_cnt_q != `DEADTIME_CYC) begin
				dead_cnt_q <= dead_cnt_q + 4'h1;
			end
			lower_gate_drive_o <= lower_req_i & upper_off
				& (dead_cnt_q == `DEADTIME_CYC);
		end
	end

endmodule

// ---- verilog/startup_configuration_latch.v ----
// Start-up configuration latch: strap sampling, start-up code and gate control
`timescale 1ns/1ps
`include "startup_consts.vh"

module startup_configuration_latch (
	// Clock and reset (reset is the supply power-on reset)
	input  wire       sys_clk_i,
	input  wire       rst_b_i,
	// Straps and control inputs
	input  wire       plane_count_strap_i,
	input  wire [1:0] offset_mode_select_i,
	input  wire       enable_i,
	input  wire       vid_serial_clk_i,
	input  wire       vid_serial_data_i,
	input  wire       power_saving_request_n_i,
	input  wire       low_current_i,
	// PWM requests and upper gate monitors, one bit per core channel
	input  wire [1:0] upper_req_i,
	input  wire [1:0] lower_req_i,
	input  wire [1:0] upper_gate_mon_i,
	// Profile outputs
	output reg        two_phase_o,
	output reg        fixed_vid_mode_o,
	output reg        serial_vid_mode_o,
	output reg        droop_en_o,
	output reg        profile_valid_o,
	output reg  [`CODE_W-1:0] startup_code_o,
	output reg        code_locked_o,
	output reg        phase1_idle_o,
	output reg        discontinuous_conduction_o,
	// Gate drives
	output wire [1:0] upper_gate_drive_o,
	output wire [1:0] lower_gate_drive_o
);

	localparam [2:0] ST_WAIT_POR = `ST_WAIT_POR;
	localparam [2:0] ST_PROFILE  = `ST_PROFILE;
	localparam [2:0] ST_READY    = `ST_READY;
	localparam [2:0] ST_RUN      = `ST_RUN;

	// ==========================================================
	// Start-up code decode
	// ==========================================================
	// Fixed table codes 0..3 (1.4,1.2,1.0,0.8 V), metal codes 4..7 (1.1,1.0,0.9,0.8 V)
	function [`CODE_W-1:0] decode_code;
		input       fixed;
		input       clk_lvl;
		input       dat_lvl;
		begin
			decode_code = {~fixed, clk_lvl, dat_lvl};
		end
	endfunction

	// ==========================================================
	// Mode pin decode
	// ==========================================================
	// Result is {fixed, serial, droop}; an unused level falls back to droop mode
	function [2:0] decode_mode;
		input [1:0] lvl;
		begin
			case (lvl)
				`MODE_LVL_BIAS: begin
					decode_mode = 3'h2;
				end
				`MODE_LVL_3V3: begin
					decode_mode = 3'h4;
				end
				default: begin
					decode_mode = 3'h3;
				end
			endcase
		end
	endfunction

	reg  [2:0]         state_q;
	reg  [2:0]         state_d;
	reg                enable_q;
	wire               enable_rise;
	wire               run;
	wire               sample_win;
	wire               lock_now;
	wire [2:0]         mode_bits;
	wire [`CODE_W-1:0] code_now;

	assign enable_rise = enable_i & ~enable_q;
	assign run         = (state_q == ST_RUN);
	// Straps are looked at only before enable, never in reset or run
	assign sample_win  = (state_q == ST_PROFILE || state_q == ST_READY) & ~enable_i;
	assign lock_now    = (state_q == ST_READY) & enable_rise;
	assign mode_bits   = decode_mode(offset_mode_select_i);
	assign code_now    = decode_code(fixed_vid_mode_o,
		vid_serial_clk_i, vid_serial_data_i);

	// ==========================================================
	// Sequencer
	// ==========================================================
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_WAIT_POR: begin
				state_d = ST_PROFILE;
			end
			ST_PROFILE: begin
				if (!enable_i) begin
					state_d = ST_READY;
				end
			end
			ST_READY: begin
				if (enable_rise) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!enable_i) begin
					state_d = ST_PROFILE;
				end
			end
			default: begin
				state_d = ST_WAIT_POR;
			end
		endcase
	end

	// ==========================================================
	// Sequencer state
	// ==========================================================
	// Enable history resets high: an enable already high at release is no rising edge
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q  <= ST_WAIT_POR;
			enable_q <= 1'b1;
		end else begin
			state_q  <= state_d;
			enable_q <= enable_i;
		end
	end

	// ==========================================================
	// Profile latch
	// ==========================================================
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			two_phase_o       <= 1'b0;
			fixed_vid_mode_o  <= 1'b0;
			serial_vid_mode_o <= 1'b0;
			droop_en_o        <= 1'b0;
			profile_valid_o   <= 1'b0;
		end else if (sample_win) begin
			two_phase_o       <= plane_count_strap_i;
			fixed_vid_mode_o  <= mode_bits[2];
			serial_vid_mode_o <= mode_bits[1];
			droop_en_o        <= mode_bits[0];
			profile_valid_o   <= 1'b1;
		end else if (run && !enable_i) begin
			profile_valid_o   <= 1'b0;
		end
	end

	// ==========================================================
	// Start-up code hold register
	// ==========================================================
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			startup_code_o <= {`CODE_W{1'b0}};
			code_locked_o  <= 1'b0;
		end else if (lock_now) begin
			startup_code_o <= code_now;
			code_locked_o  <= 1'b1;
		end else if (run && !enable_i) begin
			code_locked_o  <= 1'b0;
		end
	end

	// ==========================================================
	// Phase idling
	// ==========================================================
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase1_idle_o <= 1'b0;
		end else begin
			phase1_idle_o <= run & two_phase_o & low_current_i;
		end
	end

	// ==========================================================
	// Discontinuous conduction
	// ==========================================================
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			discontinuous_conduction_o <= 1'b0;
		end else begin
			discontinuous_conduction_o <= run & two_phase_o
				& ~power_saving_request_n_i;
		end
	end

	// ==========================================================
	// Gate guards, one per core channel
	// ==========================================================
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			wire ch_run;
			assign ch_run = run & ~(ch == 1 && phase1_idle_o);
			gate_guard u_guard (
				.sys_clk_i          (sys_clk_i),
				.rst_b_i            (rst_b_i),
				.run_i              (ch_run),
				.upper_req_i        (upper_req_i[ch]),
				.lower_req_i        (lower_req_i[ch] | (~discontinuous_conduction_o
					& ~upper_req_i[ch])),
				.upper_gate_mon_i   (upper_gate_mon_i[ch]),
				.upper_gate_drive_o (upper_gate_drive_o[ch]),
				.lower_gate_drive_o (lower_gate_drive_o[ch])
			);
		end
	endgenerate

endmodule

// ---- verilog/startup_consts.vh ----
// Constants for the start-up configuration latch
`ifndef STARTUP_CONSTS_VH
`define STARTUP_CONSTS_VH

// Mode select pin levels, two bits from the three-state detector
`define MODE_LVL_GROUND   2'h0
`define MODE_LVL_3V3      2'h1
`define MODE_LVL_BIAS     2'h2

// Start-up states
`define ST_WAIT_POR       3'h0
`define ST_PROFILE        3'h1
`define ST_READY          3'h2
`define ST_RUN            3'h3

// Start-up code: index into the start-up voltage table
`define CODE_W            3

// Lower gate turn-on delay after upper gate is seen off: 20 ns at the 4 ns clock
`define DEADTIME_CYC      4'h5

`endif
